// ==== obmn_navigator.v ====
// One-button front-panel menu navigator: press classifier, menu walk,
// contrast and language settings, exit conditions.
// Assumes a debounced button input synchronous to sys_clk.
//
// Overview of operation
// [RULE1] A long press opens the menu, descends a level or selects a configurable item.
// [RULE2] A short press steps to the next item of the current level.
// [RULE3] Level one holds hardware, languages, network, software and back.
// [RULE4] Each screen is informative, configurable or return, and every sub-level ends in back.
// [RULE5] Hardware holds temperature, contrast, date-time and back; only contrast opens level three.
// [RULE6] Each short press in the contrast screen raises the shown contrast by one step.
// [RULE7] A short press at maximum contrast wraps the shown value to the minimum.
// [RULE8] A long press in the contrast screen commits the shown value and goes up one level.
// [RULE9] A long press on a language item applies English, Portuguese or Spanish.
// [RULE10] A long press on level-one back closes the menu.
// [RULE11] A short press on another bus module closes the menu at once and shows that module.
// [RULE12] More than 5 s without button activity closes the menu.
// [RULE13] Software holds firmware, bootloader, auxiliary processor; network holds address and mask.
// [RULE14] Press length is compared with a threshold, giving one pulse per release.

`timescale 1ns/1ps
`default_nettype none
`include "obmn_regs.vh"

module obmn_navigator #(
    parameter [31:0] LONG_CYC = `OBMN_LONG_CYC,
    parameter [31:0] IDLE_CYC = `OBMN_IDLE_CYC
) (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       clk_en,
    input  wire       button,
    input  wire       other_short,
    output reg        menu_open,
    output reg  [1:0] level,
    output reg  [2:0] top_item,
    output reg  [2:0] sub_item,
    output reg  [1:0] screen_type,
    output reg  [3:0] contrast,
    output reg  [3:0] contrast_shown,
    output reg  [1:0] language,
    output reg        show_other,
    output reg        short_evt,
    output reg        long_evt
);

    // Last item index of each second-level list
    function [2:0] last_sub;
        input [2:0] top;
        begin
            case (top)
                `OBMN_TOP_HARDWARE:  last_sub = `OBMN_SUB_HW_BACK;
                `OBMN_TOP_LANGUAGES: last_sub = `OBMN_SUB_LANG_BACK;
                `OBMN_TOP_NETWORK:   last_sub = `OBMN_SUB_NET_BACK;
                `OBMN_TOP_SOFTWARE:  last_sub = `OBMN_SUB_SW_BACK;
                default:             last_sub = 3'h0;
            endcase
        end
    endfunction

    // Screen type from position in the tree
    function [1:0] kind_of;
        input [1:0] lvl;
        input [2:0] top;
        input [2:0] sub;
        begin
            if (lvl == `OBMN_LVL_THREE)
                kind_of = `OBMN_TYPE_CONFIG;
            else if (lvl == `OBMN_LVL_ONE)
                kind_of = (top == `OBMN_TOP_BACK) ? `OBMN_TYPE_RETURN : `OBMN_TYPE_INFO;
            else if (sub == last_sub(top))
                kind_of = `OBMN_TYPE_RETURN; // RULE4
            else if (top == `OBMN_TOP_LANGUAGES)
                kind_of = `OBMN_TYPE_CONFIG;
            else if (top == `OBMN_TOP_HARDWARE && sub == `OBMN_SUB_HW_CONTRAST)
                kind_of = `OBMN_TYPE_CONFIG;
            else
                kind_of = `OBMN_TYPE_INFO; // RULE13
        end
    endfunction

    // Menu depth codes; closed means the status screen is shown
    localparam [1:0] LVL_CLOSED = `OBMN_LVL_CLOSED;
    localparam [1:0] LVL_ONE    = `OBMN_LVL_ONE;
    localparam [1:0] LVL_TWO    = `OBMN_LVL_TWO;
    localparam [1:0] LVL_THREE  = `OBMN_LVL_THREE;

    reg        btn_prev;
    reg [31:0] hold_cnt;
    reg [31:0] idle_cnt;

    // Press classifier: counter saturates so very long holds stay long
    always @(posedge sys_clk) begin
        if (rst) begin
            btn_prev  <= 1'b0;
            hold_cnt  <= 32'h0;
            short_evt <= 1'b0;
            long_evt  <= 1'b0;
        end else if (clk_en) begin
            btn_prev  <= button;
            short_evt <= 1'b0;
            long_evt  <= 1'b0;
            if (button) begin
                if (hold_cnt != 32'hffffffff)
                    hold_cnt <= hold_cnt + 32'h1;
            end else begin
                hold_cnt <= 32'h0;
            end
            // Count equals held edges here; no wrap at saturation
            if (btn_prev && !button) begin
                if (hold_cnt >= LONG_CYC)
                    long_evt <= 1'b1; // RULE14
                else
                    short_evt <= 1'b1; // RULE14
            end
        end
    end

    reg [1:0] next_level;
    reg [2:0] next_top;
    reg [2:0] next_sub;
    reg [3:0] next_shown;
    reg [3:0] next_contrast;
    reg [1:0] next_lang;
    reg       next_other;
    reg       idle_expired;

    always @* begin
        idle_expired  = (idle_cnt >= IDLE_CYC);
        next_level    = level;
        next_top      = top_item;
        next_sub      = sub_item;
        next_shown    = contrast_shown;
        next_contrast = contrast;
        next_lang     = language;
        next_other    = show_other;
        if (other_short) begin
            next_level = `OBMN_LVL_CLOSED; // RULE11
            next_other = 1'b1; // RULE11
        end else if (level != `OBMN_LVL_CLOSED && idle_expired) begin
            next_level = `OBMN_LVL_CLOSED; // RULE12
        end else begin
            case (level)
                LVL_CLOSED: begin
                    if (long_evt) begin
                        next_level = `OBMN_LVL_ONE; // RULE1
                        next_top   = `OBMN_TOP_HARDWARE;
                        next_other = 1'b0;
                    end
                end
                LVL_ONE: begin
                    if (short_evt)
                        next_top = (top_item == `OBMN_TOP_BACK) ?
                                   `OBMN_TOP_HARDWARE : top_item + 3'h1; // RULE2 RULE3
                    else if (long_evt && top_item == `OBMN_TOP_BACK)
                        next_level = `OBMN_LVL_CLOSED; // RULE10
                    else if (long_evt) begin
                        next_level = `OBMN_LVL_TWO; // RULE1
                        next_sub   = 3'h0;
                    end
                end
                LVL_TWO: begin
                    if (short_evt)
                        next_sub = (sub_item == last_sub(top_item)) ?
                                   3'h0 : sub_item + 3'h1; // RULE2
                    else if (long_evt) begin
                        if (sub_item == last_sub(top_item))
                            next_level = `OBMN_LVL_ONE; // RULE4
                        else if (top_item == `OBMN_TOP_HARDWARE &&
                                 sub_item == `OBMN_SUB_HW_CONTRAST) begin
                            next_level = `OBMN_LVL_THREE; // RULE5
                            next_shown = contrast;
                        end else if (top_item == `OBMN_TOP_LANGUAGES)
                            next_lang = sub_item[1:0]; // RULE9
                    end
                end
                LVL_THREE: begin
                    if (short_evt)
                        next_shown = (contrast_shown == `OBMN_CONTRAST_MAX) ?
                                     `OBMN_CONTRAST_MIN : // RULE7
                                     contrast_shown + 4'h1; // RULE6
                    else if (long_evt) begin
                        next_contrast = contrast_shown; // RULE8
                        next_level    = `OBMN_LVL_TWO; // RULE8
                    end
                end
                default: next_level = `OBMN_LVL_CLOSED;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            idle_cnt       <= 32'h0;
            level          <= `OBMN_LVL_CLOSED;
            menu_open      <= 1'b0;
            top_item       <= `OBMN_TOP_HARDWARE;
            sub_item       <= 3'h0;
            screen_type    <= `OBMN_TYPE_INFO;
            contrast       <= `OBMN_CONTRAST_RST;
            contrast_shown <= `OBMN_CONTRAST_RST;
            language       <= `OBMN_LANG_ENGLISH;
            show_other     <= 1'b0;
        end else if (clk_en) begin
            // Any press edge or release counts as activity
            if (button || btn_prev || level == `OBMN_LVL_CLOSED)
                idle_cnt <= 32'h0;
            else if (!idle_expired)
                idle_cnt <= idle_cnt + 32'h1; // RULE12
            level          <= next_level;
            menu_open      <= (next_level != `OBMN_LVL_CLOSED);
            top_item       <= next_top;
            sub_item       <= next_sub;
            screen_type    <= kind_of(next_level, next_top, next_sub);
            contrast       <= next_contrast;
            contrast_shown <= next_shown;
            language       <= next_lang;
            show_other     <= next_other;
        end
    end

endmodule

`default_nettype wire

// ==== obmn_regs.vh ====
// Constants for the one-button menu navigator.
// Assumes a 25 MHz system clock; included by its bare name.
`ifndef OBMN_REGS_VH
`define OBMN_REGS_VH

`define OBMN_CLK_HZ          25000000
`define OBMN_IDLE_MS         5000
`define OBMN_IDLE_CYC        ((`OBMN_CLK_HZ / 1000) * `OBMN_IDLE_MS)
`define OBMN_LONG_MS         1000
`define OBMN_LONG_CYC        ((`OBMN_CLK_HZ / 1000) * `OBMN_LONG_MS)

`define OBMN_LVL_CLOSED      2'h0
`define OBMN_LVL_ONE         2'h1
`define OBMN_LVL_TWO         2'h2
`define OBMN_LVL_THREE       2'h3

`define OBMN_TOP_HARDWARE    3'h0
`define OBMN_TOP_LANGUAGES   3'h1
`define OBMN_TOP_NETWORK     3'h2
`define OBMN_TOP_SOFTWARE    3'h3
`define OBMN_TOP_BACK        3'h4
`define OBMN_TOP_COUNT       3'h5

`define OBMN_SUB_HW_TEMP     3'h0
`define OBMN_SUB_HW_CONTRAST 3'h1
`define OBMN_SUB_HW_DATE     3'h2
`define OBMN_SUB_HW_BACK     3'h3
`define OBMN_SUB_LANG_BACK   3'h3
`define OBMN_SUB_NET_BACK    3'h2
`define OBMN_SUB_SW_BACK     3'h3

`define OBMN_TYPE_INFO       2'h0
`define OBMN_TYPE_CONFIG     2'h1
`define OBMN_TYPE_RETURN     2'h2

`define OBMN_LANG_ENGLISH    2'h0
`define OBMN_LANG_PORTUGUESE 2'h1
`define OBMN_LANG_SPANISH    2'h2

`define OBMN_CONTRAST_W      4
`define OBMN_CONTRAST_MIN    4'h0
`define OBMN_CONTRAST_MAX    4'hf
`define OBMN_CONTRAST_RST    4'h8

`endif

// ==== obmn_operator.sv ====
// Operator model: holds the diagnostic button for a requested count.
// Assumes go rises only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module obmn_operator (
    input  wire       sys_clk,
    input  wire       go,
    input  wire [7:0] hold,
    output reg        button,
    output reg        busy
);
    initial begin
        button = 1'b0;
        busy = 1'b0;
    end
    // Button is high at exactly hold sampling edges
    always @(posedge go) begin
        busy = 1'b1;
        @(posedge sys_clk);
        #1 button = 1'b1;
        repeat (hold) @(posedge sys_clk);
        #1 button = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 busy = 1'b0;
    end
endmodule
`default_nettype wire

// ==== obmn_navigator_checker.sv ====
// Port assertions for the menu navigator.
// Bound into every obmn_navigator instance.
`timescale 1ns/1ps
`default_nettype none
module obmn_navigator_checker #(
    parameter [31:0] LONG_CYC = 4,
    parameter [31:0] IDLE_CYC = 50
) (
    input wire       sys_clk,
    input wire       rst,
    input wire       clk_en,
    input wire       button,
    input wire       other_short,
    input wire       menu_open,
    input wire       show_other,
    input wire       short_evt,
    input wire       long_evt,
    input wire [1:0] level,
    input wire [1:0] screen_type,
    input wire [1:0] language,
    input wire [2:0] top_item,
    input wire [2:0] sub_item,
    input wire [3:0] contrast,
    input wire [3:0] contrast_shown
);
    // Other-module touch outranks any event
    wire ok = clk_en && !other_short;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_open_flag: assert property (menu_open == (level != 2'h0))
        else $error("open flag wrong");
    chk_long_opens: assert property (long_evt && level == 2'h0 && ok
        |=> level == 2'h1 && top_item == 3'h0) else $error("menu not opened");
    chk_short_step: assert property (short_evt && level == 2'h1 && ok
        |=> top_item == ($past(top_item) == 3'h4 ? 3'h0 : $past(top_item) + 3'h1))
        else $error("item step wrong");
    chk_contrast_in: assert property (long_evt && level == 2'h2 && top_item == 3'h0
        && sub_item == 3'h1 && ok |=> level == 2'h3 && contrast_shown == $past(contrast))
        else $error("contrast screen not entered");
    chk_contrast_step: assert property (short_evt && level == 2'h3 && ok
        |=> contrast_shown == $past(contrast_shown) + 4'h1) else $error("contrast step wrong");
    chk_contrast_commit: assert property (long_evt && level == 2'h3 && ok
        |=> level == 2'h2 && contrast == $past(contrast_shown)) else $error("no commit");
    chk_lang_apply: assert property (long_evt && level == 2'h2 && top_item == 3'h1
        && sub_item < 3'h3 && ok |=> {1'b0, language} == $past(sub_item))
        else $error("language not applied");
    chk_back_close: assert property (long_evt && level == 2'h1 && top_item == 3'h4 && ok
        |=> level == 2'h0) else $error("back did not close");
    chk_other_exit: assert property (other_short && clk_en |=> level == 2'h0 && show_other)
        else $error("other touch ignored");
    chk_one_event: assert property ($fell(button) && clk_en |=> (short_evt != long_evt)
        ##1 !short_evt && !long_evt) else $error("release event wrong");
    chk_screen_kind: assert property (level == 2'h1
        |-> screen_type == (top_item == 3'h4 ? 2'h2 : 2'h0)) else $error("screen kind wrong");
    cov_wrap: cover property (short_evt && level == 2'h3 && contrast_shown == 4'hf);
    cov_spanish: cover property (long_evt && level == 2'h2 && top_item == 3'h1 && sub_item == 3'h2);
    cov_idle_exit: cover property (level == 2'h2 ##1 level == 2'h0);
endmodule
bind obmn_navigator obmn_navigator_checker #(.LONG_CYC(LONG_CYC), .IDLE_CYC(IDLE_CYC)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .button(button), .other_short(other_short),
    .menu_open(menu_open), .show_other(show_other), .short_evt(short_evt), .long_evt(long_evt),
    .level(level), .screen_type(screen_type), .language(language), .top_item(top_item),
    .sub_item(sub_item), .contrast(contrast), .contrast_shown(contrast_shown));
`default_nettype wire

// ==== obmn_navigator_tb.sv ====
// Self-checking bench for the menu navigator with short counts.
// Assumes the operator model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "obmn_regs.vh"
module obmn_navigator_tb;
    reg        sys_clk, rst, other_short, go, clk_en;
    reg  [7:0] hold;
    reg  [3:0] exp_c;
    wire       button, busy, menu_open, show_other, short_evt, long_evt;
    wire [1:0] level, screen_type, language;
    wire [2:0] top_item, sub_item;
    wire [3:0] contrast, contrast_shown;
    integer    errors, compares, rs, i, k;
    obmn_operator op (.sys_clk(sys_clk), .go(go), .hold(hold), .button(button), .busy(busy));
    obmn_navigator #(.LONG_CYC(32'h4), .IDLE_CYC(32'h32)) uut (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .button(button),
        .other_short(other_short), .menu_open(menu_open), .level(level),
        .top_item(top_item), .sub_item(sub_item), .screen_type(screen_type),
        .contrast(contrast), .contrast_shown(contrast_shown), .language(language),
        .show_other(show_other), .short_evt(short_evt), .long_evt(long_evt));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task complete_run;
        begin
            if (errors == 0 && compares > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [8*6:1] nm, input [3:0] e, input [3:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("Error %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task press(input [7:0] h);
        begin
            hold = h;
            go = 1'b1;
            @(posedge sys_clk);
            #1 go = 1'b0;
            wait (busy == 1'b0);
            @(posedge sys_clk);
            #1;
        end
    endtask
    // Short presses of 1 to 3 cycles, 3 being the longest short one
    task shorts(input integer n);
        integer j;
        begin
            for (j = 0; j < n; j = j + 1)
                press(8'($urandom % 3 + 1));
        end
    endtask
    initial begin
        errors = 0;
        compares = 0;
        go = 1'b0;
        hold = 8'h0;
        other_short = 1'b0;
        clk_en = 1'b1;
        rst = 1'b1;
        rs = $urandom(32'hb5d2);
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        chk("con", `OBMN_CONTRAST_RST, contrast);
        chk("lang", 4'h0, {2'h0, language});
        press(8'h3);
        chk("lvl", 4'h0, {2'h0, level});
        press(8'h4);
        chk("lvl", 4'h1, {2'h0, level});
        chk("open", 4'h1, {3'h0, menu_open});
        k = $urandom % 10;
        shorts(k);
        chk("top", 4'(k % 5), {1'b0, top_item});
        shorts((5 - k % 5) % 5);
        press(8'h4);
        shorts(1);
        chk("sub", 4'h1, {1'b0, sub_item});
        press(8'h4);
        chk("lvl", 4'h3, {2'h0, level});
        chk("type", 4'h1, {2'h0, screen_type});
        k = 8 + $urandom % 13;
        shorts(k);
        exp_c = 4'(8 + k);
        chk("shown", exp_c, contrast_shown);
        press(8'h4);
        chk("con", exp_c, contrast);
        for (i = 0; i < 4; i = i + 1) begin
            other_short = 1'b1;
            @(posedge sys_clk);
            #1 other_short = 1'b0;
            chk("oth", 4'h3, {2'h0, level == 2'h0, show_other});
            if (i < 3) begin
                press(8'h4);
                chk("oth", 4'h0, {3'h0, show_other});
                shorts(1);
                press(8'h4);
                shorts(i);
                press(8'h4);
                chk("lang", 4'(i), {2'h0, language});
            end
        end
        press(8'h4);
        shorts(4);
        chk("type", 4'h2, {2'h0, screen_type});
        press(8'h4);
        chk("lvl", 4'h0, {2'h0, level});
        press(8'h4);
        shorts(2);
        press(8'h4);
        chk("type", 4'h0, {2'h0, screen_type});
        repeat (40) @(posedge sys_clk);
        #1 chk("lvl", 4'h2, {2'h0, level});
        // Frozen idle count must not run out while the enable is low
        clk_en = 1'b0;
        repeat (30) @(posedge sys_clk);
        #1 chk("lvl", 4'h2, {2'h0, level});
        clk_en = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1 chk("lvl", 4'h0, {2'h0, level});
        // Mid-run reset restores the reset contrast and the English language
        rst = 1'b1;
        @(posedge sys_clk);
        #1 rst = 1'b0;
        chk("con", `OBMN_CONTRAST_RST, contrast);
        chk("lang", 4'h0, {2'h0, language});
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors = errors + 1;
        complete_run;
    end
endmodule
`default_nettype wire
